//--- logic/csc_pkg.sv
/*
 * Constants, types and register map of the codec serial timing control block.
 * Assumes one 100 MHz system clock that also stands for the master clock input.
 */
// How it works
// R1: Async mode: transmit and bandpass filter clocks come from separate dividers.
// R2: Async mode: DAC and ADC conversion strobes come from separate divider chains.
// R3: Sync mode: the transmit filter clock also drives the bandpass filter.
// R4: Sync mode: ADC conversion strobe is the DAC conversion strobe.
// R5: A control bit, written over the serial link, inserts or bypasses sine compensation.
// R6: When inserted, sine compensation follows the low-pass filter stage.
// R7: Four serial modes: async or sync, each with byte or word framing.
// R8: Reset puts every register, control included, at its initial value.
// R9: Loopback routes the analog output pair back into the main input pair.
// R10: The processor switches loopback by a control bit sent over the serial input.
// R11: In loopback, returned ADC bits 15 to 2 follow the DAC bits 15 to 2.
// R12: Input-select bit 1 picks the auxiliary input pair, 0 the main pair.
// R13: ADC result bits leave on the serial output, timed by our shift clock.
// R14: DAC and control bits arrive on the serial input, captured with our shift clock.
// R15: Word mode: end marker pulses low right after the 16th bit.
// R16: Byte mode: end marker low after first byte until second byte completes.
// R17: Byte frame: sync low, byte, marker low, 4-cycle sync pulse, byte, marker high, sync high.
// R18: Word frame: sync low, 16 bits, sync high, then a low end-marker pulse.
// R19: Sync mode: no receive frame sync during a secondary control transfer.
// R20: Reset loads both conversion-rate adjust registers with 1.
// R21: Serial words go most significant bit first, one bit per shift clock period.
package csc_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SHIFT_PERIOD_NS = 80;
	localparam int SHIFT_HALF_CYC  = SHIFT_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [2:0] SHIFT_HALF_LAST = 3'(SHIFT_HALF_CYC - 1);

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_TXDIV  = 8'h04;
	localparam logic [7:0] ADDR_RXDIV  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;

	// Control word bit positions and value after reset.
	localparam int CTRL_HIGHPASS = 2;
	localparam int CTRL_LOOPBACK = 3;
	localparam int CTRL_AUXSEL   = 4;
	localparam int CTRL_SYNC     = 5;
	localparam int CTRL_SINCOMP  = 7;
	localparam logic [15:0] CTRL_RESET = 16'h02e4;

	typedef struct packed {
		logic [7:0] rateAdjust;
		logic [7:0] divB;
		logic [7:0] divA;
	} csc_div_t;

	localparam csc_div_t DIV_RESET = '{rateAdjust: 8'h01, divB: 8'h24, divA: 8'h12};

	// ==========================================================
	// Framing
	localparam logic [3:0] LAST_BIT      = 4'hf;
	localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
	localparam logic [2:0] GAP_LAST      = 3'h3;
	localparam logic [1:0] SECONDARY_REQ = 2'h3;

	typedef enum logic [3:0] {
		FR_IDLE = 4'b0001,
		FR_DATA = 4'b0010,
		FR_GAP  = 4'b0100,
		FR_END  = 4'b1000
	} csc_frame_t;

endpackage

//--- logic/csc_serial_timing.sv
/*
 * Digital control of the codec: filter clock and conversion dividers,
 * the serial port framer for both directions, and an APB register slave.
 * Assumes the serial partner drives the data input on the rising shift clock
 * edge; that input and the word/byte strap arrive from outside and are synchronised.
 */
// Implementation choices: the APB register port and the address map.
`timescale 1ns/100ps
module csc_serial_timing (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        wordModePin,
	input  wire logic        dacSerialIn,
	input  wire logic [15:0] adcResult,
	output logic             shiftClk,
	output logic             adcSerialOut,
	output logic             transmitFrameSync,
	output logic             receiveFrameSync,
	output logic             transmitEndMarker,
	output logic             receiveEndMarker,
	output logic             txFilterClk,
	output logic             bandpassFilterClk,
	output logic             dacConvert,
	output logic             adcConvert,
	output logic             sinCompInsert,
	output logic             highpassEnable,
	output logic             loopbackRoute,
	output logic             auxInputSelect,
	output logic      [15:0] dacData,
	output logic             dacLoad
);

	// ==========================================================
	// Pin synchronisers
	logic [1:0] pinMeta;
	logic [1:0] pinSync;

	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta <= 2'h0;
			pinSync <= 2'h0;
		end else begin
			pinMeta <= {wordModePin, dacSerialIn};
			pinSync <= pinMeta;
		end
	end

	wire dxBit    = pinSync[0];
	wire wordMode = pinSync[1];

	// ==========================================================
	// Registers
	logic [15:0]       ctrl;
	csc_pkg::csc_div_t divCfg [2];
	logic [15:0]       dacWord;
	logic              secPending;
	logic              frameDone [2];
	logic [15:0]       frameWord [2];
	csc_pkg::csc_frame_t frState [2];

	wire syncMode = ctrl[csc_pkg::CTRL_SYNC];
	wire loopback = ctrl[csc_pkg::CTRL_LOOPBACK];

	// ==========================================================
	// APB slave: one wait state, registered read data.
	wire accessNow = psel & penable & ~pready;
	wire writeFire = psel & penable & pready & pwrite;
	wire hitCtrl   = (paddr == csc_pkg::ADDR_CTRL);
	wire hitTxDiv  = (paddr == csc_pkg::ADDR_TXDIV);
	wire hitRxDiv  = (paddr == csc_pkg::ADDR_RXDIV);
	wire hitStatus = (paddr == csc_pkg::ADDR_STATUS);
	wire hitAny    = hitCtrl | hitTxDiv | hitRxDiv | hitStatus;
	wire txBusy    = (frState[0] != csc_pkg::FR_IDLE);
	wire rxBusy    = (frState[1] != csc_pkg::FR_IDLE);
	wire [31:0] statusWord = {12'h000, secPending, syncMode, rxBusy, txBusy, dacWord};
	wire [31:0] readMux;

	assign readMux = hitCtrl   ? {16'h0000, ctrl} :
	                 hitTxDiv  ? {8'h00, divCfg[0]} :
	                 hitRxDiv  ? {8'h00, divCfg[1]} :
	                 hitStatus ? statusWord : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= accessNow;
			if (accessNow) begin
				prdata  <= readMux;
				pslverr <= ~hitAny;
			end
		end
	end

	// Transmit frame completion: data word or secondary control word.
	wire txDone = frameDone[0];

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl       <= csc_pkg::CTRL_RESET; // [R8]
			divCfg[0]  <= csc_pkg::DIV_RESET; // [R20]
			divCfg[1]  <= csc_pkg::DIV_RESET; // [R20]
			dacWord    <= 16'h0000;
			secPending <= 1'b0;
		end else begin
			if (writeFire && hitCtrl) begin
				ctrl <= pwdata[15:0];
			end
			if (writeFire && hitTxDiv) begin
				divCfg[0] <= pwdata[23:0];
			end
			if (writeFire && hitRxDiv) begin
				divCfg[1] <= pwdata[23:0];
			end
			if (txDone) begin
				if (secPending) begin
					ctrl       <= frameWord[0]; // [R5] [R10]
					secPending <= 1'b0;
				end else begin
					dacWord    <= frameWord[0];
					secPending <= (frameWord[0][1:0] == csc_pkg::SECONDARY_REQ);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dacData <= 16'h0000;
			dacLoad <= 1'b0;
		end else begin
			dacLoad <= txDone & ~secPending;
			if (txDone && !secPending) begin
				dacData <= frameWord[0];
			end
		end
	end

	// Analog path steering; compensation sits right after the low-pass stage when set.
	assign sinCompInsert  = ctrl[csc_pkg::CTRL_SINCOMP]; // [R5] [R6]
	assign highpassEnable = ctrl[csc_pkg::CTRL_HIGHPASS];
	assign loopbackRoute  = ctrl[csc_pkg::CTRL_LOOPBACK]; // [R9]
	assign auxInputSelect = ctrl[csc_pkg::CTRL_AUXSEL]; // [R12]

	// ==========================================================
	// Shift clock divider
	logic [2:0] shCnt;
	logic       shRise;
	logic       shFall;

	always_ff @(posedge clk) begin
		if (rst) begin
			shCnt    <= 3'h0;
			shiftClk <= 1'b0;
			shRise   <= 1'b0;
			shFall   <= 1'b0;
		end else begin
			shRise <= (shCnt == csc_pkg::SHIFT_HALF_LAST) & ~shiftClk;
			shFall <= (shCnt == csc_pkg::SHIFT_HALF_LAST) & shiftClk;
			if (shCnt == csc_pkg::SHIFT_HALF_LAST) begin
				shCnt    <= 3'h0;
				shiftClk <= ~shiftClk;
			end else begin
				shCnt <= shCnt + 3'h1;
			end
		end
	end

	// ==========================================================
	// Filter clock and conversion dividers; index 0 transmit, 1 receive.
	logic [7:0] filtCnt [2];
	logic       filtClk [2];
	logic [7:0] convCnt [2];
	logic       convTick [2];

	for (genvar d = 0; d < 2; d++) begin : g_div
		wire filtTick = (filtCnt[d] >= divCfg[d].divA - 8'h01);
		wire filtEdge = filtTick & ~filtClk[d];
		wire convWrap = (convCnt[d] >= divCfg[d].divB - 8'h01);

		always_ff @(posedge clk) begin
			if (rst) begin
				filtCnt[d]  <= 8'h00;
				filtClk[d]  <= 1'b0;
				convCnt[d]  <= 8'h00;
				convTick[d] <= 1'b0;
			end else begin
				convTick[d] <= filtEdge & convWrap; // [R2]
				if (filtTick) begin
					filtCnt[d] <= 8'h00;
					filtClk[d] <= ~filtClk[d]; // [R1]
				end else begin
					filtCnt[d] <= filtCnt[d] + 8'h01;
				end
				if (filtEdge) begin
					convCnt[d] <= convWrap ? 8'h00 : convCnt[d] + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			txFilterClk       <= 1'b0;
			bandpassFilterClk <= 1'b0;
			dacConvert        <= 1'b0;
			adcConvert        <= 1'b0;
		end else begin
			txFilterClk       <= filtClk[0];
			bandpassFilterClk <= syncMode ? filtClk[0] : filtClk[1]; // [R1] [R3]
			dacConvert        <= convTick[0];
			adcConvert        <= syncMode ? convTick[0] : convTick[1]; // [R2] [R4]
		end
	end

	// ==========================================================
	// ADC word hold; loopback returns DAC bits 15 to 2 through the converter path.
	logic [15:0] adcHold;
	logic        startPulse [2];
	logic [15:0] loadWord [2];

	always_ff @(posedge clk) begin
		if (rst) begin
			adcHold <= 16'h0000;
		end else if (startPulse[1]) begin
			adcHold <= loopback ? {dacWord[15:2], 2'h0} : adcResult; // [R11]
		end
	end

	assign startPulse[0] = convTick[0];
	assign startPulse[1] = syncMode ? (convTick[0] & ~secPending) : convTick[1]; // [R4] [R19]
	assign loadWord[0]   = 16'h0000;
	assign loadWord[1]   = adcHold;

	// ==========================================================
	// Framers: channel 0 captures the serial input, channel 1 drives the output.
	logic       frSync [2];
	logic       frEnd [2];
	logic       startReq [2];
	logic [3:0] bitCnt [2];
	logic [2:0] gapCnt [2];

	for (genvar c = 0; c < 2; c++) begin : g_frame
		localparam bit DRIVES_OUT = (c == 1);
		wire beginFrame = (frState[c] == csc_pkg::FR_IDLE) & startReq[c] & shRise;
		wire lastBit    = (bitCnt[c] == csc_pkg::LAST_BIT);
		wire byteBreak  = ~wordMode & (bitCnt[c] == csc_pkg::BYTE_LAST_BIT); // [R7]

		always_ff @(posedge clk) begin
			if (rst) begin
				frState[c]   <= csc_pkg::FR_IDLE;
				frSync[c]    <= 1'b1;
				frEnd[c]     <= 1'b1;
				startReq[c]  <= 1'b0;
				bitCnt[c]    <= 4'h0;
				gapCnt[c]    <= 3'h0;
				frameWord[c] <= 16'h0000;
				frameDone[c] <= 1'b0;
			end else begin
				frameDone[c] <= 1'b0;
				startReq[c]  <= startPulse[c] | (startReq[c] & ~beginFrame);
				case (frState[c])
					csc_pkg::FR_IDLE: begin
						if (beginFrame) begin
							frState[c]   <= csc_pkg::FR_DATA;
							frSync[c]    <= 1'b0; // [R17] [R18]
							bitCnt[c]    <= 4'h0;
							frameWord[c] <= loadWord[c];
						end
					end
					csc_pkg::FR_DATA: begin
						if (shFall && !DRIVES_OUT) begin
							frameWord[c] <= {frameWord[c][14:0], dxBit}; // [R14] [R21]
						end
						if (shRise) begin
							if (lastBit) begin
								frSync[c]    <= 1'b1;
								frameDone[c] <= 1'b1;
								if (wordMode) begin
									frEnd[c]   <= 1'b0; // [R15] [R18]
									frState[c] <= csc_pkg::FR_END;
								end else begin
									frEnd[c]   <= 1'b1; // [R16] [R17]
									frState[c] <= csc_pkg::FR_IDLE;
								end
							end else begin
								bitCnt[c] <= bitCnt[c] + 4'h1;
								if (DRIVES_OUT) begin
									frameWord[c] <= {frameWord[c][14:0], 1'b0}; // [R13] [R21]
								end
								if (byteBreak) begin
									frEnd[c]   <= 1'b0; // [R16]
									frSync[c]  <= 1'b1; // [R17]
									gapCnt[c]  <= 3'h0;
									frState[c] <= csc_pkg::FR_GAP;
								end
							end
						end
					end
					csc_pkg::FR_GAP: begin
						if (shRise) begin
							if (gapCnt[c] == csc_pkg::GAP_LAST) begin
								frSync[c]  <= 1'b0; // [R17]
								frState[c] <= csc_pkg::FR_DATA;
							end else begin
								gapCnt[c] <= gapCnt[c] + 3'h1;
							end
						end
					end
					csc_pkg::FR_END: begin
						if (shRise) begin
							frEnd[c]   <= 1'b1; // [R15]
							frState[c] <= csc_pkg::FR_IDLE;
						end
					end
					default: begin
						frState[c] <= csc_pkg::FR_IDLE;
					end
				endcase
			end
		end
	end

	assign transmitFrameSync = frSync[0];
	assign receiveFrameSync  = frSync[1];
	assign transmitEndMarker = frEnd[0];
	assign receiveEndMarker  = frEnd[1];
	assign adcSerialOut      = frameWord[1][15];

endmodule

//--- tb/csc_serial_timing_checker.sv
/* Port assertions for the codec serial timing control block.
   Assumes the bench holds the word/byte strap and adcResult steady during frames. */
`timescale 1ns/100ps
module csc_serial_timing_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        wordModePin,
	input wire logic [15:0] adcResult,
	input wire logic        shiftClk,
	input wire logic        adcSerialOut,
	input wire logic        transmitFrameSync,
	input wire logic        receiveFrameSync,
	input wire logic        receiveEndMarker,
	input wire logic        txFilterClk,
	input wire logic        bandpassFilterClk,
	input wire logic        dacConvert,
	input wire logic        adcConvert,
	input wire logic        loopbackRoute,
	input wire logic [15:0] dacData
);
	// ==========================================================
	// Mode shadow and properties
	logic syncMode;
	always_ff @(posedge clk) begin
		if (rst)
			syncMode <= 1'b1;
		else if (psel && penable && pready && pwrite && paddr == csc_pkg::ADDR_CTRL)
			syncMode <= pwdata[csc_pkg::CTRL_SYNC];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_sync_filter_clk: assert property (syncMode && $past(syncMode, 2) |-> bandpassFilterClk == txFilterClk)
		else $error("filter clocks differ");
	a_sync_conv_same: assert property (syncMode && $past(syncMode, 2) |-> adcConvert == dacConvert)
		else $error("conversion strobes differ");
	a_sync_frames_tie: assert property (syncMode && !receiveFrameSync |-> !transmitFrameSync)
		else $error("receive frame alone");
	a_shift_period: assert property ($rose(shiftClk) |-> shiftClk[*4] ##1 !shiftClk[*4] ##1 shiftClk)
		else $error("shift clock period");
	a_bits_on_rise: assert property ($changed(adcSerialOut) && !receiveFrameSync
		|-> $past(shiftClk) && !$past(shiftClk, 2))
		else $error("bit moved off rise");
	a_msb_first: assert property ($fell(receiveFrameSync) && wordModePin && !loopbackRoute
		|-> adcSerialOut == adcResult[15])
		else $error("first bit not msb");
	a_loop_msb: assert property ($fell(receiveFrameSync) && wordModePin && loopbackRoute
		|-> adcSerialOut == dacData[15])
		else $error("loopback msb");
	a_word_end_pulse: assert property ($rose(receiveFrameSync) && wordModePin
		|-> !receiveEndMarker[*8] ##1 receiveEndMarker)
		else $error("word end marker");
	a_word_len: assert property ($fell(receiveFrameSync) && wordModePin
		|-> ##127 !receiveFrameSync ##1 receiveFrameSync)
		else $error("word frame length");
	a_byte_gap: assert property ($rose(receiveFrameSync) && !receiveEndMarker && !wordModePin
		|-> ##31 receiveFrameSync ##1 !receiveFrameSync)
		else $error("byte gap width");
	a_byte_marker: assert property ($fell(receiveEndMarker) && !wordModePin
		|-> ##95 !receiveEndMarker ##1 receiveEndMarker)
		else $error("byte marker width");
	c_byte: cover property ($fell(receiveFrameSync) && !wordModePin);
	c_loop: cover property ($fell(receiveFrameSync) && loopbackRoute);
	c_async: cover property (!syncMode && adcConvert);
endmodule
bind csc_serial_timing csc_serial_timing_checker chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .wordModePin, .adcResult, .shiftClk, .adcSerialOut, .transmitFrameSync, .receiveFrameSync,
	.receiveEndMarker, .txFilterClk, .bandpassFilterClk, .dacConvert, .adcConvert, .loopbackRoute, .dacData);

//--- tb/csc_dsp_model.sv
/* Behavioural processor serial port facing the codec link.
   Assumes it shares the system clock and sees the codec shift clock as data. */
`timescale 1ns/100ps
module csc_dsp_model (
	input  wire logic        clk,
	input  wire logic        shiftClk,
	input  wire logic        transmitFrameSync,
	input  wire logic        receiveFrameSync,
	input  wire logic        transmitEndMarker,
	input  wire logic        receiveEndMarker,
	input  wire logic        adcSerialOut,
	input  wire logic [15:0] txWord,
	output logic             dacSerialIn = 1'b0,
	output logic      [15:0] rxWord = '0,
	output logic             txDone = 1'b0,
	output logic             rxDone = 1'b0
);
	// ==========================================================
	// Link shifting
	logic       lastSclk = 1'b0;
	logic       prevSclk = 1'b0;
	logic [4:0] txCnt = '0;
	logic [4:0] rxCnt = '0;
	// Bits move two clocks after the shift clock rise, once frame sync has settled.
	wire        rise = lastSclk && !prevSclk;
	wire        fall = !shiftClk && lastSclk;
	wire        txIdle = transmitFrameSync && transmitEndMarker;
	wire        rxIdle = receiveFrameSync && receiveEndMarker;
	always @(posedge clk) begin
		lastSclk <= shiftClk;
		prevSclk <= lastSclk;
		txDone <= txIdle && txCnt == 5'd16;
		rxDone <= rxIdle && rxCnt == 5'd16;
		if (txIdle)
			txCnt <= '0;
		if (rxIdle)
			rxCnt <= '0;
		// Outside a frame the data line toggles so stale bits cannot pass.
		if (rise && !transmitFrameSync && txCnt < 5'd16) begin
			dacSerialIn <= txWord[4'hf - txCnt[3:0]];
			txCnt <= txCnt + 5'd1;
		end else if (rise)
			dacSerialIn <= !dacSerialIn;
		if (fall && !receiveFrameSync && rxCnt < 5'd16) begin
			rxWord <= {rxWord[14:0], adcSerialOut};
			rxCnt <= rxCnt + 5'd1;
		end
	end
endmodule

//--- tb/csc_serial_timing_tb.sv
/* Self-checking bench for the codec serial timing control block.
   Assumes the design package is compiled first and the checker is bound. */
`timescale 1ns/100ps
module csc_serial_timing_tb;
	// ==========================================================
	// Signals and instances
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wordModePin = 1, err;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [15:0] adcResult = 16'hc35a, txWord = '0, rxWord, dacData;
	logic pready, pslverr, dacSerialIn, shiftClk, adcSerialOut, transmitFrameSync, receiveFrameSync;
	logic transmitEndMarker, receiveEndMarker, txFilterClk, bandpassFilterClk, dacConvert, adcConvert;
	logic sinCompInsert, highpassEnable, loopbackRoute, auxInputSelect, dacLoad, txDone, rxDone;
	int nFail = 0, totalChecks = 0, nLoads = 0, n0 = 0;
	int cnt [4];
	int per [4];
	logic [3:0] monQ = '0;
	csc_serial_timing dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.wordModePin, .dacSerialIn, .adcResult, .shiftClk, .adcSerialOut, .transmitFrameSync,
		.receiveFrameSync, .transmitEndMarker, .receiveEndMarker, .txFilterClk, .bandpassFilterClk,
		.dacConvert, .adcConvert, .sinCompInsert, .highpassEnable, .loopbackRoute, .auxInputSelect,
		.dacData, .dacLoad);
	csc_dsp_model dsp (.clk, .shiftClk, .transmitFrameSync, .receiveFrameSync, .transmitEndMarker,
		.receiveEndMarker, .adcSerialOut, .txWord, .dacSerialIn, .rxWord, .txDone, .rxDone);
	initial forever #5 clk = ~clk;
	// Cycles between rising edges of the filter clocks and conversion strobes.
	wire [3:0] mon = {adcConvert, dacConvert, bandpassFilterClk, txFilterClk};
	always @(posedge clk) begin
		monQ <= mon;
		if (dacLoad === 1'b1)
			nLoads <= nLoads + 1;
		for (int i = 0; i < 4; i++) begin
			if (mon[i] && !monQ[i]) begin
				per[i] <= cnt[i];
				cnt[i] <= 1;
			end else
				cnt[i] <= cnt[i] + 1;
		end
	end
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic frame(logic [15:0] w);
		txWord <= w;
		do @(posedge clk); while (txDone !== 1'b1);
		repeat (2) @(posedge clk);
	endtask
	task automatic conclude();
		$display("Checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("outs", 6'b110011, {sinCompInsert, highpassEnable, loopbackRoute, auxInputSelect,
			receiveFrameSync, receiveEndMarker});
		apb(1'b0, csc_pkg::ADDR_CTRL, '0);
		check("ctrl", 32'h02e4, rd);
		apb(1'b0, csc_pkg::ADDR_TXDIV, '0);
		check("txdiv", 32'h012412, rd);
		apb(1'b0, csc_pkg::ADDR_RXDIV, '0);
		check("rxdiv", 32'h012412, rd);
		apb(1'b0, 8'h10, '0);
		check("unmapped", 32'h1, {rd[30:0], err});
		apb(1'b1, csc_pkg::ADDR_CTRL, 32'h0274);
		repeat (2) @(posedge clk);
		check("sincomp aux", 2'b01, {sinCompInsert, auxInputSelect});
		$display("Test registers done");
		frame(16'h0000);
		frame(16'ha5c4);
		check("dac word", 16'ha5c4, dacData);
		check("adc word", 16'hc35a, rxWord);
		n0 = nLoads;
		frame(16'h0003);
		frame(16'h02ec);
		check("serial ctrl", 3'b110, {sinCompInsert, loopbackRoute, auxInputSelect});
		check("dac held", 16'h0003, dacData);
		check("dac loads", 32'd1, nLoads - n0);
		frame(16'h123a);
		frame(16'h0000);
		check("loopback", 16'h1238, rxWord);
		$display("Test word sync done");
		apb(1'b1, csc_pkg::ADDR_CTRL, 32'h02c4);
		apb(1'b1, csc_pkg::ADDR_RXDIV, 32'h012010);
		apb(1'b0, csc_pkg::ADDR_RXDIV, '0);
		check("rxdiv wr", 32'h012010, rd);
		wordModePin <= 1'b0;
		frame(16'h5a3c);
		check("byte dac", 16'h5a3c, dacData);
		do @(posedge clk); while (rxDone !== 1'b1);
		check("byte adc", 16'hc35a, rxWord);
		check("tx filter period", 32'd36, per[0]);
		check("bandpass period", 32'd32, per[1]);
		check("dac conv period", 32'd1296, per[2]);
		check("adc conv period", 32'd1024, per[3]);
		$display("Test byte async done");
		wordModePin <= 1'b1;
		adcResult <= 16'h9669;
		frame(16'h3c5a);
		check("word async dac", 16'h3c5a, dacData);
		do @(posedge clk); while (rxDone !== 1'b1);
		check("word async adc", 16'h9669, rxWord);
		$display("Test word async done");
		apb(1'b1, csc_pkg::ADDR_CTRL, 32'h02e4);
		wordModePin <= 1'b0;
		adcResult <= 16'h5aa5;
		frame(16'h0ff0);
		check("byte sync dac", 16'h0ff0, dacData);
		check("byte sync adc", 16'h5aa5, rxWord);
		$display("Test byte sync done");
		conclude();
	end
	initial begin
		repeat (40000) @(posedge clk);
		nFail++;
		$display("Error watchdog expected finish seen timeout");
		conclude();
	end
endmodule
